// ---- ucs_chan_ctrl.sv ----
// apb slave with clock select and command decode for two serial channels
// assumes shifters, status and counter/timer sit outside and use the strobes
`timescale 1ns/10ps
`include "ucs_cfg.svh"
module ucs_chan_ctrl
	import ucs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ref_double,
	input  wire logic [1:0]  tx_busy,
	input  wire logic [1:0]  rx_char_moved,
	output logic      [1:0]  rx_enable,
	output logic      [1:0]  tx_enable,
	output logic      [1:0]  rx_flush,
	output logic      [1:0]  tx_flush,
	output logic      [1:0]  err_clear,
	output logic      [1:0]  brk_change_clear,
	output logic      [1:0]  mode_ptr_one,
	output logic      [1:0]  mode_ptr_zero,
	output logic      [1:0]  tx_force_low,
	output logic      [1:0]  rts_n,
	output logic      [7:0]  tx_rate_code,
	output logic      [7:0]  rx_rate_code,
	output logic      [1:0]  rate_set,
	output logic             rate_double,
	output logic      [5:0]  tx_clk_src,
	output logic      [5:0]  rx_clk_src,
	output logic             timeout_mode,
	output logic             timer_restart,
	output logic             timer_stop,
	output logic             timer_ready_clear,
	output logic             power_down
);
	logic        wr_stb;
	logic        rd_stb;
	logic [1:0]  cmd_stb;
	logic [7:0]  csr_r [2];
	logic [7:0]  mode0_r [2];
	logic [7:0]  aux_r;
	logic [1:0]  rx_en_r;
	logic [1:0]  tx_en_r;
	logic [1:0]  rts_n_r;
	logic [1:0]  brk_force_r;
	logic [1:0]  to_chan_r;
	logic        pd_r;
	logic [1:0]  rx_flush_r;
	logic [1:0]  tx_flush_r;
	logic [1:0]  err_clr_r;
	logic [1:0]  brkc_clr_r;
	logic [1:0]  ptr1_r;
	logic [1:0]  ptr0_r;
	logic        t_restart_r;
	logic        t_stop_r;
	logic        t_rdyclr_r;
	logic [31:0] prdata_r;
	logic [1:0]  dbl_sync_r;
	logic        dbl_r;
	logic        dbl_q3_r;

	assign wr_stb  = psel && penable && pwrite;
	assign rd_stb  = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign cmd_stb = {wr_stb && paddr == `UCS_OFF_CMD_B, wr_stb && paddr == `UCS_OFF_CMD_A};

	// reference clock strap through two sync flops and a third, then held until two samples agree
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dbl_sync_r <= 2'b00;
			dbl_q3_r   <= 1'b0;
			dbl_r      <= 1'b0;
		end else begin
			dbl_sync_r <= {dbl_sync_r[0], ref_double};
			dbl_q3_r   <= dbl_sync_r[1];
			if (dbl_sync_r[1] == dbl_q3_r) begin
				dbl_r <= dbl_q3_r;
			end
		end
	end

	// plain configuration registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aux_r <= `UCS_RST_BYTE;
		end else if (wr_stb && paddr == `UCS_OFF_AUX) begin
			aux_r <= pwdata[7:0];
		end
	end

	// apb read mux, unmapped reads zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_r <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`UCS_OFF_MODE0_A: prdata_r <= {24'h0, mode0_r[0]};
				`UCS_OFF_MODE0_B: prdata_r <= {24'h0, mode0_r[1]};
				`UCS_OFF_AUX:     prdata_r <= {24'h0, aux_r};
				`UCS_OFF_STAT:    prdata_r <= {21'h0, rts_n_r[1], tx_en_r[1], rx_en_r[1],
					pd_r, to_chan_r, brk_force_r, rts_n_r[0], tx_en_r[0], rx_en_r[0]};
				`UCS_OFF_RATE_A:  prdata_r <= {24'h0, csr_r[0]};
				`UCS_OFF_RATE_B:  prdata_r <= {24'h0, csr_r[1]};
				default:          prdata_r <= 32'h0;
			endcase
		end
	end
	assign prdata  = prdata_r;
	assign pslverr = 1'b0;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic [3:0] misc;
			logic [1:0] rxf;
			logic [1:0] txf;
			logic       go;
			ucs_brk_t   brk_st_r;
			assign misc = pwdata[7:4];
			assign rxf  = pwdata[1:0];
			assign txf  = pwdata[3:2];
			assign go   = cmd_stb[g] && (!pd_r || (g == 0 && misc == `UCS_MC_PDOFF));

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					csr_r[g]   <= `UCS_RST_BYTE;
					mode0_r[g] <= `UCS_RST_BYTE;
				end else begin
					if (wr_stb && !pd_r && paddr == (g ? `UCS_OFF_CSR_B : `UCS_OFF_CSR_A)) begin
						csr_r[g] <= pwdata[7:0];
					end
					if (wr_stb && paddr == (g ? `UCS_OFF_MODE0_B : `UCS_OFF_MODE0_A)) begin
						mode0_r[g] <= pwdata[7:0];
					end
				end
			end

			assign tx_rate_code[g*4 +: 4] = csr_r[g][3:0];
			assign rx_rate_code[g*4 +: 4] = csr_r[g][7:4];
			assign rate_set[g] = aux_r[`UCS_AUX_SET_BIT];
			assign tx_clk_src[g*3 +: 3] = csr_r[g][3:0] >= `UCS_CODE_EXT16 ? UCS_SRC_EXT
				: csr_r[g][3:0] == `UCS_CODE_TIMER ? UCS_SRC_TIMER : UCS_SRC_TABLE;
			assign rx_clk_src[g*3 +: 3] = csr_r[g][7:4] >= `UCS_CODE_EXT16 ? UCS_SRC_EXT
				: csr_r[g][7:4] == `UCS_CODE_TIMER ? UCS_SRC_TIMER : UCS_SRC_TABLE;

			// all fields decoded in one write
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					rx_en_r[g] <= 1'b0;
				end else if (go) begin
					if (misc == `UCS_MC_RXRST || rxf == `UCS_FLD_OFF) begin
						rx_en_r[g] <= 1'b0;
					end else if (rxf == `UCS_FLD_ON) begin
						rx_en_r[g] <= 1'b1;
					end
				end
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					tx_en_r[g] <= 1'b0;
				end else if (go) begin
					if (misc == `UCS_MC_TXRST || txf == `UCS_FLD_OFF) begin
						tx_en_r[g] <= 1'b0;
					end else if (txf == `UCS_FLD_ON) begin
						tx_en_r[g] <= 1'b1;
					end
				end
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					ptr1_r[g]     <= 1'b0;
					ptr0_r[g]     <= 1'b0;
					rx_flush_r[g] <= 1'b0;
					tx_flush_r[g] <= 1'b0;
					err_clr_r[g]  <= 1'b0;
					brkc_clr_r[g] <= 1'b0;
				end else begin
					ptr1_r[g]     <= go && misc == `UCS_MC_PTR1;
					ptr0_r[g]     <= go && misc == `UCS_MC_PTR0;
					rx_flush_r[g] <= go && misc == `UCS_MC_RXRST;
					tx_flush_r[g] <= go && misc == `UCS_MC_TXRST;
					err_clr_r[g]  <= go && misc == `UCS_MC_ERRCLR;
					brkc_clr_r[g] <= go && misc == `UCS_MC_BRKCLR;
				end
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					rts_n_r[g] <= 1'b1;
				end else if (go && misc == `UCS_MC_RTSLO) begin
					rts_n_r[g] <= 1'b0;
				end else if (go && misc == `UCS_MC_RTSHI) begin
					rts_n_r[g] <= 1'b1;
				end
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					brk_st_r  <= UCS_BRK_IDLE;
				end else begin
					unique case (brk_st_r)
						UCS_BRK_IDLE: begin
							if (go && misc == `UCS_MC_BRKON && tx_en_r[g]) begin
								brk_st_r <= UCS_BRK_WAIT;
							end
						end
						UCS_BRK_WAIT: begin
							if (go && misc == `UCS_MC_BRKOFF) begin
								brk_st_r <= UCS_BRK_IDLE;
							end else if (!tx_busy[g]) begin
								brk_st_r <= UCS_BRK_ON;
							end
						end
						UCS_BRK_ON: begin
							if (go && misc == `UCS_MC_BRKOFF) begin
								brk_st_r <= UCS_BRK_IDLE;
							end
						end
					endcase
				end
			end
			assign brk_force_r[g] = brk_st_r == UCS_BRK_ON;

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					to_chan_r[g] <= 1'b0;
				end else if (go && misc == `UCS_MC_TOON) begin
					to_chan_r[g] <= 1'b1;
				end else if (go && misc == `UCS_MC_TOOFF) begin
					to_chan_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// timer stop and ready clear on entry
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			t_restart_r <= 1'b0;
			t_stop_r    <= 1'b0;
			t_rdyclr_r  <= 1'b0;
		end else begin
			t_restart_r <= |(to_chan_r & rx_char_moved);
			t_stop_r    <= |(cmd_stb & {2{!pd_r && pwdata[7:4] == `UCS_MC_TOON}});
			t_rdyclr_r  <= |(cmd_stb & {2{!pd_r && pwdata[7:4] == `UCS_MC_TOON}});
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pd_r <= 1'b0;
		end else if (cmd_stb[0] && pwdata[7:4] == `UCS_MC_PDON) begin
			pd_r <= 1'b1;
		end else if (cmd_stb[0] && pwdata[7:4] == `UCS_MC_PDOFF) begin
			pd_r <= 1'b0;
		end
	end

	assign rate_double       = dbl_r;
	assign rx_enable         = rx_en_r;
	assign tx_enable         = tx_en_r;
	assign rx_flush          = rx_flush_r;
	assign tx_flush          = tx_flush_r;
	assign err_clear         = err_clr_r;
	assign brk_change_clear  = brkc_clr_r;
	assign mode_ptr_one      = ptr1_r;
	assign mode_ptr_zero     = ptr0_r;
	assign tx_force_low      = brk_force_r;
	assign rts_n             = rts_n_r;
	assign timeout_mode      = |to_chan_r;
	assign timer_restart     = t_restart_r;
	assign timer_stop        = t_stop_r;
	assign timer_ready_clear = t_rdyclr_r;
	assign power_down        = pd_r;

	// assertions
	rx_cmd_on_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[0] && !pd_r && pwdata[1:0] == 2'b01 && pwdata[7:4] != 4'h2 |=> rx_enable[0])
		else $error("receiver not enabled");
	rx_cmd_off_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[0] && !pd_r && pwdata[1:0] == 2'b10 |=> !rx_enable[0])
		else $error("receiver not disabled");
	tx_cmd_on_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[1] && !pd_r && pwdata[3:2] == 2'b01 && pwdata[7:4] != 4'h3 |=> tx_enable[1])
		else $error("transmitter not enabled");
	tx_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[0] && !pd_r && pwdata[7:4] == 4'h3 |=> tx_flush[0] && !tx_enable[0])
		else $error("transmitter reset missed");
	rts_low_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[0] && !pd_r && pwdata[7:4] == 4'h8 |=> !rts_n[0])
		else $error("rts not asserted");
	brk_release_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[0] && !pd_r && pwdata[7:4] == 4'h7 |=> !tx_force_low[0])
		else $error("break not released");
	pd_enter_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[0] && pwdata[7:4] == 4'he |=> power_down)
		else $error("power-down not entered");
	pd_chan_b_a: assert property (@(posedge clk) disable iff (!reset_n)
		!cmd_stb[0] && cmd_stb[1] && pwdata[7:4] == 4'he && !power_down |=> !power_down)
		else $error("power-down via channel b");
	to_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[0] && !pd_r && pwdata[7:4] == 4'ha |=> timer_stop && timer_ready_clear
		&& timeout_mode) else $error("timeout entry effects missing");
	ptr_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[1] && !pd_r && pwdata[7:4] == 4'hb |=> mode_ptr_zero[1] ##1 !mode_ptr_zero[1])
		else $error("pointer strobe wrong");
	err_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[0] && !pd_r && pwdata[7:4] == `UCS_MC_ERRCLR |=> err_clear[0])
		else $error("error clear missed");
	brkc_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[1] && !pd_r && pwdata[7:4] == `UCS_MC_BRKCLR |=> brk_change_clear[1])
		else $error("break change clear missed");
	rx_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_stb[1] && !pd_r && pwdata[7:4] == `UCS_MC_RXRST |=> rx_flush[1] && !rx_enable[1])
		else $error("receiver reset missed");
	brk_cov: cover property (@(posedge clk) disable iff (!reset_n) tx_force_low[0]);
	dbl_cov: cover property (@(posedge clk) disable iff (!reset_n) rate_double);
	lock_cov: cover property (@(posedge clk) disable iff (!reset_n) power_down && cmd_stb[0]);
	pd_cov: cover property (@(posedge clk) disable iff (!reset_n) power_down ##1 !power_down);
	to_cov: cover property (@(posedge clk) disable iff (!reset_n) timer_restart);
endmodule // ucs_chan_ctrl

// ---- ucs_cfg.svh ----
// register offsets, fields and command codes for the channel control block
// assumes a 32-bit apb master and a single 25 MHz clock
`ifndef UCS_CFG_SVH
`define UCS_CFG_SVH
`define UCS_OFF_CSR_A     12'h000
`define UCS_OFF_CMD_A     12'h004
`define UCS_OFF_CSR_B     12'h008
`define UCS_OFF_CMD_B     12'h00c
`define UCS_OFF_MODE0_A   12'h010
`define UCS_OFF_MODE0_B   12'h014
`define UCS_OFF_AUX       12'h018
`define UCS_OFF_STAT      12'h01c
`define UCS_OFF_RATE_A    12'h020
`define UCS_OFF_RATE_B    12'h024
`define UCS_RST_BYTE      8'h00
`define UCS_FLD_ON        2'b01
`define UCS_FLD_OFF       2'b10
`define UCS_MC_PTR1       4'h1
`define UCS_MC_RXRST      4'h2
`define UCS_MC_TXRST      4'h3
`define UCS_MC_ERRCLR     4'h4
`define UCS_MC_BRKCLR     4'h5
`define UCS_MC_BRKON      4'h6
`define UCS_MC_BRKOFF     4'h7
`define UCS_MC_RTSLO      4'h8
`define UCS_MC_RTSHI      4'h9
`define UCS_MC_TOON       4'ha
`define UCS_MC_PTR0       4'hb
`define UCS_MC_TOOFF      4'hc
`define UCS_MC_PDON       4'he
`define UCS_MC_PDOFF      4'hf
`define UCS_CODE_EXT16    4'he
`define UCS_CODE_EXT1     4'hf
`define UCS_CODE_TIMER    4'hd
`define UCS_AUX_SET_BIT   7
`define UCS_M0_EXT1_BIT   0
`define UCS_M0_EXT2_BIT   2
`define UCS_BIT_US        104
`define UCS_CLK_NS        40
`define UCS_BRK_CYC       ((2*`UCS_BIT_US*1000)/`UCS_CLK_NS)
`endif

// ---- ucs_pkg.sv ----
// types for the channel control block
// assumes ucs_cfg.svh holds all numeric constants
package ucs_pkg;
	typedef enum logic [2:0] {
		UCS_BRK_IDLE = 3'b001,
		UCS_BRK_WAIT = 3'b010,
		UCS_BRK_ON   = 3'b100
	} ucs_brk_t;
	typedef enum logic [2:0] {
		UCS_SRC_TABLE = 3'b001,
		UCS_SRC_TIMER = 3'b010,
		UCS_SRC_EXT   = 3'b100
	} ucs_src_t;
endpackage

// ---- ucs_host.sv ----
// apb master model standing in for the host cpu
// assumes one clock and a slave that raises pready when done
`timescale 1ns/10ps
module ucs_host (
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready
);
	logic [31:0] rdata;
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rdata = 32'h0;
	end
	// one setup then access until pready
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (!pready) begin
			@(posedge clk);
		end
		rdata = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
endmodule // ucs_host

// ---- tb.sv ----
// self-checking bench for the channel control block
// assumes apb slave outputs settle within 1 ns of the write edge
`timescale 1ns/10ps
`include "ucs_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb
	import ucs_pkg::*;
;
	logic        clk = 1'h0;
	logic        reset_n = 1'h0;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        ref_double = 1'h0;
	logic [1:0]  tx_busy = 2'h0;
	logic [1:0]  rx_char_moved = 2'h0;
	logic [1:0]  rx_enable, tx_enable, rx_flush, tx_flush, err_clear;
	logic [1:0]  brk_change_clear, mode_ptr_one, mode_ptr_zero, tx_force_low, rts_n;
	logic [1:0]  rate_set;
	logic [7:0]  tx_rate_code, rx_rate_code;
	logic [5:0]  tx_clk_src, rx_clk_src;
	logic        rate_double, timeout_mode, timer_restart, timer_stop;
	logic        timer_ready_clear, power_down;
	int          fails = 0;
	int          n_compared = 0;
	int          cyc = 0;
	always #20 clk = ~clk;
	ucs_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
	ucs_chan_ctrl u_ucs_chan_ctrl (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_double(ref_double),
		.tx_busy(tx_busy), .rx_char_moved(rx_char_moved), .rx_enable(rx_enable),
		.tx_enable(tx_enable), .rx_flush(rx_flush), .tx_flush(tx_flush),
		.err_clear(err_clear), .brk_change_clear(brk_change_clear),
		.mode_ptr_one(mode_ptr_one), .mode_ptr_zero(mode_ptr_zero),
		.tx_force_low(tx_force_low), .rts_n(rts_n), .tx_rate_code(tx_rate_code),
		.rx_rate_code(rx_rate_code), .rate_set(rate_set), .rate_double(rate_double),
		.tx_clk_src(tx_clk_src), .rx_clk_src(rx_clk_src), .timeout_mode(timeout_mode),
		.timer_restart(timer_restart), .timer_stop(timer_stop),
		.timer_ready_clear(timer_ready_clear), .power_down(power_down));
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		u_host.xfer(1'h1, a, d);
		#1;
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_enable();
		`CHK("rts_rst", 2'h3, rts_n)
		wr(`UCS_OFF_CMD_A, 8'h45);
		`CHK("rx_on", 1'h1, rx_enable[0])
		`CHK("tx_on", 1'h1, tx_enable[0])
		`CHK("errclr", 1'h1, err_clear[0])
		wr(`UCS_OFF_CMD_A, 8'hdf);
		`CHK("code11", 2'h3, {rx_enable[0], tx_enable[0]})
		wr(`UCS_OFF_CMD_A, 8'h0a);
		`CHK("both_off", 2'h0, {rx_enable[0], tx_enable[0]})
		$display("test enable done");
	endtask
	task automatic t_misc();
		logic [3:0] mc [7] = '{4'h1, 4'hb, 4'h2, 4'h3, 4'h5, 4'h8, 4'h9};
		logic [5:0] ev [7] = '{6'h21, 6'h11, 6'h09, 6'h05, 6'h03, 6'h00, 6'h01};
		for (int i = 0; i < 7; i++) begin
			wr(`UCS_OFF_CMD_B, {mc[i], 4'h0});
			`CHK("misc_b", ev[i], {mode_ptr_one[1], mode_ptr_zero[1], rx_flush[1], tx_flush[1], brk_change_clear[1], rts_n[1]})
		end
		$display("test misc done");
	endtask
	task automatic t_csr();
		wr(`UCS_OFF_CSR_B, 8'he5);
		`CHK("txcode_b", 4'h5, tx_rate_code[7:4])
		`CHK("rxcode_b", 4'he, rx_rate_code[7:4])
		`CHK("src_b", 6'h21, {rx_clk_src[5:3], tx_clk_src[5:3]})
		wr(`UCS_OFF_CSR_A, 8'hdf);
		wr(`UCS_OFF_MODE0_A, 8'h05);
		wr(`UCS_OFF_AUX, 8'h80);
		`CHK("src_a", 6'h14, {rx_clk_src[2:0], tx_clk_src[2:0]})
		`CHK("set2", 1'h1, rate_set[0])
		u_host.xfer(1'h0, `UCS_OFF_RATE_B, 8'h00);
		`CHK("rdback", 32'he5, u_host.rdata)
		u_host.xfer(1'h0, 12'h030, 8'h00);
		`CHK("unmapped", 32'h0, u_host.rdata)
		ref_double <= 1'h1;
		repeat (6) @(posedge clk);
		`CHK("dbl", 1'h1, rate_double)
		$display("test csr done");
	endtask
	task automatic t_break();
		wr(`UCS_OFF_CMD_A, 8'h04);
		tx_busy <= 2'h1;
		wr(`UCS_OFF_CMD_A, 8'h60);
		repeat (4) @(posedge clk);
		`CHK("brk_wait", 1'h0, tx_force_low[0])
		tx_busy <= 2'h0;
		repeat (4) @(posedge clk);
		`CHK("brk_on", 1'h1, tx_force_low[0])
		wr(`UCS_OFF_CMD_A, 8'h70);
		repeat (2) @(posedge clk);
		`CHK("brk_off", 1'h0, tx_force_low[0])
		wr(`UCS_OFF_CMD_A, 8'h08);
		wr(`UCS_OFF_CMD_A, 8'h60);
		repeat (4) @(posedge clk);
		`CHK("brk_dis", 1'h0, tx_force_low[0])
		$display("test break done");
	endtask
	task automatic t_timeout();
		int n;
		n = 0;
		wr(`UCS_OFF_CMD_A, 8'ha0);
		`CHK("to_on", 3'h7, {timeout_mode, timer_stop, timer_ready_clear})
		@(posedge clk);
		rx_char_moved <= 2'h1;
		@(posedge clk);
		rx_char_moved <= 2'h0;
		#1;
		while (timer_restart !== 1'h1 && n < 4) begin
			n++;
			@(posedge clk);
			#1;
		end
		`CHK("restart", 1'h1, timer_restart)
		wr(`UCS_OFF_CMD_A, 8'hc0);
		`CHK("to_off", 2'h0, {timeout_mode, timer_stop})
		$display("test timeout done");
	endtask
	task automatic t_pd();
		wr(`UCS_OFF_CMD_B, 8'he0);
		`CHK("pd_b", 1'h0, power_down)
		wr(`UCS_OFF_CMD_A, 8'he0);
		`CHK("pd_on", 1'h1, power_down)
		u_host.xfer(1'h0, `UCS_OFF_STAT, 8'h00);
		`CHK("stat", 32'h484, u_host.rdata)
		wr(`UCS_OFF_CMD_A, 8'h80);
		`CHK("pd_lock", 1'h1, rts_n[0])
		wr(`UCS_OFF_CMD_A, 8'hf0);
		`CHK("pd_off", 1'h0, power_down)
		$display("test power done");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			results();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'h1;
		t_enable();
		t_misc();
		t_csr();
		t_break();
		t_timeout();
		t_pd();
		results();
	end
endmodule // tb
